// [include/hdpm_pkg.sv]
package hdpm_pkg;
  localparam int ADDR_W = 14;
  localparam int WORD_W = 16;
  localparam int PMW_W = 24;
  localparam int MEM_DEPTH = 16384;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 14'h0001;
  localparam int TYPE_BIT = 14;
  localparam logic TYPE_DM = 1'b0;
  localparam logic TYPE_PM = 1'b1;
  localparam int FIFO_DEPTH = 4;
  localparam int PM_HI_W = PMW_W - WORD_W;
  typedef enum logic {PERS_HOSTPORT, PERS_PCI} hdpm_pers_type;
  typedef enum {ST_IDLE, ST_SYNC, ST_ACCESS, ST_DONE} hdpm_state_type;
endpackage

// [logic/hdpm_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
module hdpm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] memQ [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0] count_q;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;
  assign inReady = (count_q != (PW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = memQ[rdPtr_q];
  always_ff @(posedge ref_clk)
  begin
    if (doWrite)
    begin
      memQ[wrPtr_q] <= inData;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (doWrite)
      begin
        wrPtr_q <= PW'(wrPtr_q + 1'b1);
      end
      if (doRead)
      begin
        rdPtr_q <= PW'(rdPtr_q + 1'b1);
      end
      count_q <= (PW+1)'(count_q + doWrite - doRead);
    end
  end
endmodule
`default_nettype wire

// [logic/hdpm_port.sv]
`timescale 1ns/1ns
`default_nettype none
module hdpm_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // straps
  input wire logic busPersonalityStrap,
  input wire logic busVariantStrap,
  input wire logic bootSourceSelect,
  output logic hostPortBoot,
  output logic pciPersonality,
  // shared host bus pins, active-low read and write strobes, address latch strobe active high
  input wire logic hostReadStrobe_n,
  input wire logic hostWriteStrobe_n,
  input wire logic hostPortSelect_n,
  input wire logic addrLatchStrobe,
  output logic hostAccessAck_n,
  output logic hostAccessAckOe,
  input wire logic [hdpm_pkg::WORD_W-1:0] hostMuxedAddrDataIn,
  output logic [hdpm_pkg::WORD_W-1:0] hostMuxedAddrDataOut,
  output logic hostMuxedAddrDataOe,
  output logic hostFlagOut0,
  output logic hostFlagOut1,
  output logic hostFlagOut2,
  output logic hostInterruptOut,
  // processor side flags and interrupt source
  input wire logic [2:0] cpuFlags,
  input wire logic pciIntReq,
  // processor load of the address register
  input wire logic cpuAddrWrite,
  input wire logic [hdpm_pkg::ADDR_W:0] cpuAddrData,
  output logic [hdpm_pkg::ADDR_W:0] hostPortAddressReg,
  // memory access slot, one cycle per access, none for the first half of a program word write
  output logic memReq,
  output logic memWrite,
  output logic memIsProgram,
  output logic [hdpm_pkg::ADDR_W-1:0] memAddr,
  output logic [hdpm_pkg::PMW_W-1:0] memWrData,
  input wire logic [hdpm_pkg::PMW_W-1:0] memRdData,
  // read data drained from the buffer by the host
  output logic rdFifoValid,
  output logic busy
);
  import hdpm_pkg::*;
  hdpm_state_type state_q;
  hdpm_state_type state_d;
  hdpm_pers_type pers_q;
  logic strapsTaken_q;
  logic bootHost_q;
  logic [1:0] persStrapSync_q;
  logic [1:0] variantStrapSync_q;
  logic [1:0] bootSync_q;
  logic [1:0] strapFill_q;
  logic [2:0] rdSync_q;
  logic [2:0] wrSync_q;
  logic [2:0] selSync_q;
  logic [2:0] alSync_q;
  logic [WORD_W-1:0] dataSync1_q;
  logic [WORD_W-1:0] dataSync2_q;
  logic [ADDR_W-1:0] addr_q;
  logic type_q;
  logic isWrite_q;
  logic pmHalf_q;
  logic [PM_HI_W-1:0] pmHi_q;
  logic [PMW_W-1:0] wrData_q;
  logic [WORD_W-1:0] outData_q;
  logic fifoInReady;
  logic fifoOutValid;
  logic [WORD_W-1:0] fifoOutData;
  logic fifoInValid;
  logic [WORD_W-1:0] fifoInData;

  // IDMA pins only when both straps low at capture, and from reset until the straps are caught
  wire hostMode = (pers_q == PERS_HOSTPORT);
  wire hostPers = !persStrapSync_q[1] && !variantStrapSync_q[1];
  wire [ADDR_W:0] latchWord = dataSync2_q[TYPE_BIT:0];
  wire rdLvl = !rdSync_q[1] && !selSync_q[1] && hostMode;
  wire wrLvl = !wrSync_q[1] && !selSync_q[1] && hostMode;
  wire rdPrev = !rdSync_q[2] && !selSync_q[2];
  wire wrPrev = !wrSync_q[2] && !selSync_q[2];
  // request is select plus a strobe edge
  wire rdStart = rdLvl && !rdPrev;
  wire wrStart = wrLvl && !wrPrev;
  wire alFall = !alSync_q[1] && alSync_q[2] && hostMode;
  // program word takes two bus words, high byte first
  wire pmFirstHalf = (type_q == TYPE_PM) && !pmHalf_q;
  wire doMem = (state_q == ST_ACCESS);
  wire accessCounts = !(pmFirstHalf && isWrite_q);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if ((rdStart && fifoInReady) || wrStart)
        begin
          state_d = ST_SYNC;
        end
      end
      ST_SYNC: state_d = ST_ACCESS;
      ST_ACCESS: state_d = ST_DONE;
      ST_DONE:
      begin
        if (!rdLvl && !wrLvl)
        begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // memory request lasts exactly one cycle
  assign memReq = doMem && accessCounts;
  assign memWrite = isWrite_q;
  // type bit steers to program or data memory
  assign memIsProgram = (type_q == TYPE_PM);
  // only memory addresses ever leave this port
  assign memAddr = addr_q;
  assign memWrData = wrData_q;
  assign fifoInValid = doMem && !isWrite_q;
  assign fifoInData = pmFirstHalf ? {{(WORD_W-PM_HI_W){1'b0}}, memRdData[PMW_W-1:WORD_W]}
                                  : memRdData[WORD_W-1:0];
  assign busy = (state_q != ST_IDLE);
  assign rdFifoValid = fifoOutValid;
  assign hostAccessAck_n = !(hostMode && (state_q == ST_IDLE));
  assign hostAccessAckOe = hostMode;
  assign hostMuxedAddrDataOut = outData_q;
  assign hostMuxedAddrDataOe = rdLvl && fifoOutValid;
  assign hostFlagOut0 = hostMode && cpuFlags[0];
  assign hostFlagOut1 = hostMode && cpuFlags[1];
  assign hostFlagOut2 = hostMode && cpuFlags[2];
  assign hostInterruptOut = !hostMode && pciIntReq;
  assign pciPersonality = !hostMode;
  assign hostPortBoot = bootHost_q;
  assign hostPortAddressReg = {type_q, addr_q};

  hdpm_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) readBuffer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(rdStart),
    .outData(fifoOutData)
  );

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // idle pin levels, so reset release shows no false edge
      rdSync_q <= '1;
      wrSync_q <= '1;
      selSync_q <= '1;
      alSync_q <= '0;
      dataSync1_q <= '0;
      dataSync2_q <= '0;
    end
    else
    begin
      rdSync_q <= {rdSync_q[1:0], hostReadStrobe_n};
      wrSync_q <= {wrSync_q[1:0], hostWriteStrobe_n};
      selSync_q <= {selSync_q[1:0], hostPortSelect_n};
      alSync_q <= {alSync_q[1:0], addrLatchStrobe};
      dataSync1_q <= hostMuxedAddrDataIn;
      dataSync2_q <= dataSync1_q;
    end
  end

  // straps are pins as well, two flops before the capture reads them
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      persStrapSync_q <= '0;
      variantStrapSync_q <= '0;
      bootSync_q <= '0;
      strapFill_q <= '0;
    end
    else
    begin
      persStrapSync_q <= {persStrapSync_q[0], busPersonalityStrap};
      variantStrapSync_q <= {variantStrapSync_q[0], busVariantStrap};
      bootSync_q <= {bootSync_q[0], bootSourceSelect};
      strapFill_q <= {strapFill_q[0], 1'b1};
    end
  end

  // straps caught once after reset release
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strapsTaken_q <= 1'b0;
      pers_q <= PERS_HOSTPORT;
      bootHost_q <= 1'b0;
    end
    else if (!strapsTaken_q && strapFill_q[1])
    begin
      strapsTaken_q <= 1'b1;
      pers_q <= hostPers ? PERS_HOSTPORT : PERS_PCI;
      bootHost_q <= bootSync_q[1];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      isWrite_q <= 1'b0;
      outData_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_IDLE)
      begin
        isWrite_q <= wrStart;
      end
      if (rdStart && fifoOutValid)
      begin
        outData_q <= fifoOutData;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_q <= ADDR_RST;
      type_q <= TYPE_DM;
      pmHalf_q <= 1'b0;
      pmHi_q <= '0;
      wrData_q <= '0;
    end
    else if (alFall && state_q == ST_IDLE)
    begin
      addr_q <= dataSync2_q[ADDR_W-1:0];
      type_q <= dataSync2_q[TYPE_BIT];
      pmHalf_q <= 1'b0;
    end
    else if (cpuAddrWrite)
    begin
      addr_q <= cpuAddrData[ADDR_W-1:0];
      type_q <= cpuAddrData[TYPE_BIT];
      pmHalf_q <= 1'b0;
    end
    else
    begin
      if (wrStart && state_q == ST_IDLE)
      begin
        if (pmFirstHalf)
        begin
          pmHi_q <= dataSync2_q[PM_HI_W-1:0];
        end
        wrData_q <= (type_q == TYPE_PM) ? {pmHi_q, dataSync2_q}
                                        : {{PM_HI_W{1'b0}}, dataSync2_q};
      end
      if (doMem)
      begin
        pmHalf_q <= pmFirstHalf;
        if (!pmFirstHalf)
        begin
          addr_q <= ADDR_W'(addr_q + ADDR_ONE);
        end
      end
    end
  end

  // access lands two cycles after start
  a_sync_then_access: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == ST_IDLE && (wrStart || (rdStart && fifoInReady)))
      |-> ##1 (state_q == ST_SYNC)
      ##1 (state_q == ST_ACCESS && (memReq || (isWrite_q && pmFirstHalf))))
    else $error("access did not follow one sync cycle");
  // never two memory cycles in a row
  a_one_steal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    memReq |=> !memReq)
    else $error("more than one stolen cycle");
  a_ack_pending: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (hostMode && state_q != ST_IDLE) |-> hostAccessAck_n)
    else $error("ack asserted while pending");
  a_addr_incr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (doMem && !pmFirstHalf && !cpuAddrWrite && !alFall)
      |=> addr_q == ADDR_W'($past(addr_q) + ADDR_ONE))
    else $error("address did not increment");
  a_strap_fixed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    strapsTaken_q |=> $stable(pers_q))
    else $error("personality changed after reset");
  a_boot_fixed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    strapsTaken_q |=> $stable(bootHost_q))
    else $error("boot source changed after reset");
  // interrupt out silent in host mode
  a_pci_int: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hostMode |-> !hostInterruptOut)
    else $error("interrupt driven in host personality");
  a_addr_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (alFall && state_q == ST_IDLE) |=> hostPortAddressReg == $past(latchWord))
    else $error("address not latched");
  a_cpu_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cpuAddrWrite && !(alFall && state_q == ST_IDLE))
      |=> hostPortAddressReg == $past(cpuAddrData))
    else $error("processor address load lost");
  // a started read always finds buffer room
  a_read_room: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (doMem && !isWrite_q) |-> fifoInReady)
    else $error("read data dropped with buffer full");
endmodule
`default_nettype wire

// [sim/hdpm_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module hdpm_host_model (
  // clock and handshake
  input wire logic ref_clk,
  input wire logic hostAccessAck_n,
  // strobes and bus
  output logic hostReadStrobe_n,
  output logic hostWriteStrobe_n,
  output logic hostPortSelect_n,
  output logic addrLatchStrobe,
  output logic [hdpm_pkg::WORD_W-1:0] busOut,
  output logic busErr
);
  import hdpm_pkg::*;
  logic [WORD_W-1:0] lastVal;
  initial
  begin
    {hostReadStrobe_n, hostWriteStrobe_n, hostPortSelect_n} = 3'h7;
    addrLatchStrobe = 1'b0;
    lastVal = 16'h0000;
    busOut = 16'hffff;
    busErr = 1'b0;
  end
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask
  // bounded wait, a stuck ack is flagged
  task automatic waitAck(input logic lvl);
    int n;
    n = 0;
    while (hostAccessAck_n !== lvl && n < 50)
    begin
      step(1);
      n++;
    end
    if (n >= 50)
      busErr = 1'b1;
  endtask
  task automatic latch(input logic [ADDR_W:0] a);
    waitAck(1'b0);
    lastVal = {1'b0, a};
    busOut = lastVal;
    addrLatchStrobe = 1'b1;
    step(3);
    addrLatchStrobe = 1'b0;
    // bus held past the synchronisers
    step(4);
    busOut = ~lastVal;
    // one quiet cycle before the next request drives the bus
    step(1);
  endtask
  // select plus strobe, held until ack rises
  task automatic access(input logic wr, input logic [WORD_W-1:0] d);
    waitAck(1'b0);
    if (wr)
    begin
      lastVal = d;
      busOut = d;
    end
    hostPortSelect_n = 1'b0;
    hostWriteStrobe_n = !wr;
    hostReadStrobe_n = wr;
    waitAck(1'b1);
    {hostReadStrobe_n, hostWriteStrobe_n, hostPortSelect_n} = 3'h7;
    // released bus shows no stale value
    busOut = ~lastVal;
    waitAck(1'b0);
  endtask
endmodule
`default_nettype wire

// [sim/hdpm_port_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module hdpm_port_bench;
  import hdpm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pStrap = 1'b0;
  logic vStrap = 1'b0;
  logic bootSel = 1'b1;
  logic [2:0] cpuFlags = 3'h5;
  logic [PMW_W-1:0] memRdData = 24'h12beef;
  logic rdValid, busy;
  logic pciIntReq = 1'b0;
  logic cpuAddrWrite = 1'b0;
  logic [ADDR_W:0] cpuAddrData = 15'h0000;
  logic rdN, wrN, selN, ale, ackN, ackOe, oe, busErr, pciPers, hostBoot, intOut;
  logic [2:0] flagOut;
  logic [WORD_W-1:0] hostBus, dutOut;
  logic [ADDR_W:0] addrReg;
  logic memReq, memWrite, memIsProgram, lastWr, lastPm;
  logic [ADDR_W-1:0] memAddr, lastAddr;
  logic [PMW_W-1:0] memWrData, lastData;
  int reqCount = 0;
  int err_count = 0;
  int num_checks = 0;
  always #10 ref_clk = ~ref_clk;
  hdpm_port i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .busPersonalityStrap(pStrap),
    .busVariantStrap(vStrap), .bootSourceSelect(bootSel), .hostPortBoot(hostBoot),
    .pciPersonality(pciPers), .hostReadStrobe_n(rdN), .hostWriteStrobe_n(wrN),
    .hostPortSelect_n(selN), .addrLatchStrobe(ale), .hostAccessAck_n(ackN),
    .hostAccessAckOe(ackOe), .hostMuxedAddrDataIn(oe ? dutOut : hostBus),
    .hostMuxedAddrDataOut(dutOut), .hostMuxedAddrDataOe(oe), .hostFlagOut0(flagOut[0]),
    .hostFlagOut1(flagOut[1]), .hostFlagOut2(flagOut[2]), .hostInterruptOut(intOut),
    .cpuFlags(cpuFlags), .pciIntReq(pciIntReq), .cpuAddrWrite(cpuAddrWrite),
    .cpuAddrData(cpuAddrData), .hostPortAddressReg(addrReg), .memReq(memReq),
    .memWrite(memWrite), .memIsProgram(memIsProgram), .memAddr(memAddr),
    .memWrData(memWrData), .memRdData(memRdData), .rdFifoValid(rdValid), .busy(busy));
  hdpm_host_model i_host (.ref_clk(ref_clk), .hostAccessAck_n(ackN),
    .hostReadStrobe_n(rdN), .hostWriteStrobe_n(wrN), .hostPortSelect_n(selN),
    .addrLatchStrobe(ale), .busOut(hostBus), .busErr(busErr));
  // memory slot snapshot, one entry per stolen cycle
  always @(posedge ref_clk)
    if (memReq === 1'b1)
    begin
      reqCount <= reqCount + 1;
      {lastWr, lastPm, lastAddr, lastData} <= {memWrite, memIsProgram, memAddr, memWrData};
    end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_count++;
    end_sim();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    i_host.step(4);
    check(pciPers, 0);
    check(hostBoot, 1);
    check({ackOe, ackN}, 2'h2);
    check(flagOut, 3'h5);
    pStrap = 1'b1;
    vStrap = 1'b1;
    bootSel = 1'b0;
    cpuFlags = 3'h2;
    i_host.step(3);
    check({pciPers, hostBoot}, 2'h1);
    check(flagOut, 3'h2);
    pStrap = 1'b0;
    vStrap = 1'b0;
    i_host.latch(15'h0010);
    i_host.step(5);
    check(addrReg, 15'h0010);
    i_host.access(1'b1, 16'h1234);
    check(reqCount, 1);
    check({lastWr, lastPm, lastAddr}, {2'h2, 14'h0010});
    check(lastData[15:0], 16'h1234);
    check(addrReg, 15'h0011);
    i_host.access(1'b1, 16'h5678);
    check(reqCount, 2);
    check(lastAddr, 14'h0011);
    i_host.access(1'b0, 16'h0000);
    check({lastWr, lastAddr}, {1'b0, 14'h0012});
    // reads come back one access late, through the buffer
    i_host.access(1'b0, 16'h0000);
    check(dutOut, 16'hbeef);
    check({oe, busy, rdValid}, 3'h1);
    // top of memory, the increment wraps inside the 14-bit field
    i_host.latch({TYPE_PM, 14'h3fff});
    i_host.access(1'b1, 16'h00ab);
    i_host.access(1'b1, 16'hcdef);
    check({lastPm, lastAddr}, {1'b1, 14'h3fff});
    check(lastData, 24'habcdef);
    check(addrReg, {TYPE_PM, 14'h0000});
    check(reqCount, 5);
    cpuAddrData = 15'h4005;
    cpuAddrWrite = 1'b1;
    i_host.step(1);
    cpuAddrWrite = 1'b0;
    i_host.step(1);
    check(addrReg, 15'h4005);
    check(busErr, 0);
    rst_n = 1'b0;
    pStrap = 1'b1;
    pciIntReq = 1'b1;
    i_host.step(2);
    rst_n = 1'b1;
    i_host.step(4);
    check({pciPers, intOut, ackOe}, 3'h6);
    check(hostBoot, 0);
    check({ackN, flagOut}, 4'h8);
    end_sim();
  end
endmodule
`default_nettype wire
